// File: include/scp_pkg.sv
// scp_pkg: constants, states and timing figures of the serial control port
// assumes a 250 MHz core clock and a 14.318 MHz reference clock figure
package scp_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_PS = 4000;
    localparam int REF_PERIOD_PS = 69840;
    localparam int REF_CYCLES    = 6;
    localparam int GATE_DELAY_NS = 20;
    localparam int PS_PER_NS     = 1000;
    localparam int SDA_DELAY_PS  = REF_CYCLES * REF_PERIOD_PS + GATE_DELAY_NS * PS_PER_NS;
    localparam int DLY_W         = 8;
    localparam logic [DLY_W-1:0] SDA_DELAY_CYC =
        DLY_W'((SDA_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [DLY_W-1:0] DLY_LAST = 8'h01;
    localparam logic [DLY_W-1:0] DLY_IDLE = 8'h00;

    // ****************************************
    // transfer layout
    // ****************************************
    localparam logic [6:0] DEF_DEV_ADDR = 7'h10;
    localparam logic [7:0] IDX_ADDR     = 8'h00;
    localparam logic [7:0] IDX_CMD      = 8'h01;
    localparam logic [7:0] IDX_COUNT    = 8'h02;
    localparam logic [7:0] IDX_DATA0    = 8'h03;
    localparam logic [7:0] IDX_MAX      = 8'hff;
    localparam logic [3:0] BITS_BYTE    = 4'h8;
    localparam logic [3:0] BIT_FIRST    = 4'h1;
    localparam logic [7:0] PAD_BYTE     = 8'h00;
    localparam int         DEF_RD_COUNT = 7;
    localparam int         DEF_FIFO_D   = 4;

    // ****************************************
    // clock groups
    // ****************************************
    localparam int NUM_CH  = 2;
    localparam int CH_PCI  = 0;
    localparam int CH_LINK = 1;

    // ****************************************
    // states
    // ****************************************
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX   = 5'h02,
        ST_ACK  = 5'h04,
        ST_TX   = 5'h08,
        ST_RACK = 5'h10
    } scp_state_t;

endpackage

// File: src/scp_fifo.sv
// scp_fifo: flop-based first-in first-out buffer with valid/ready both sides
// assumes both sides on clock_in; depth of at least two
`timescale 1ns/1ns
module scp_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    input  wire logic         clock_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] in_data_in,
    input  wire logic         in_valid_in,
    output logic              in_ready_out,
    output logic [W-1:0]      out_data_out,
    output logic              out_valid_out,
    input  wire logic         out_ready_in
);
    localparam int AW = $clog2(D);
    localparam logic [AW-1:0] LAST = AW'(D - 1);
    localparam logic [AW:0]   FULL = (AW + 1)'(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } scp_fifo_state_t;

    scp_fifo_state_t s;
    scp_fifo_state_t next_s;
    logic            push;
    logic            pop;

    // ****************************************
    // pointers and count
    // ****************************************
    always_comb begin
        next_s = s;
        push = in_valid_in && (s.cnt != FULL);
        pop = (s.cnt != '0) && out_ready_in;
        if (push) begin
            next_s.mem[s.wp] = in_data_in;
            next_s.wp = (s.wp == LAST) ? '0 : AW'(s.wp + 1'b1);
        end
        if (pop) begin
            next_s.rp = (s.rp == LAST) ? '0 : AW'(s.rp + 1'b1);
        end
        next_s.cnt = (AW + 1)'(s.cnt + push - pop);
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign in_ready_out  = (s.cnt != FULL);
    assign out_valid_out = (s.cnt != '0);
    assign out_data_out  = s.mem[s.rp];
endmodule

// File: src/scp_control_port.sv
// scp_control_port: serial control port slave and clock group halt gating
// assumes host drives serial clock; pins are open drain and resolved outside
// Functional notes
// - data line changes lag each falling serial clock by six reference cycles plus 20 ns
// - repeated start is taken like a fresh start and the new transfer proceeds
// - serial clock is never held low; host must not expect stretching
// - bytes run address, ignored command, count, then data bytes from zero
// - halt changes gate clock outputs only at pulse boundaries, keeping duty cycle
// - after halt setup no pulse is sent; after release setup a pulse is sent
`timescale 1ns/1ns
module scp_control_port #(
    parameter logic [6:0] DEV_ADDR = scp_pkg::DEF_DEV_ADDR,
    parameter int         RD_COUNT = scp_pkg::DEF_RD_COUNT,
    parameter int         FIFO_D   = scp_pkg::DEF_FIFO_D
) (
    input  wire logic                     clock_in,
    input  wire logic                     rst_n_in,
    input  wire logic                     serial_clock_line_in,
    input  wire logic                     serial_data_line_in,
    output logic                          serial_data_line_out,
    output logic                          serial_data_line_en_n_out,
    input  wire logic                     pci_clock_src_in,
    input  wire logic                     link_clock_src_in,
    input  wire logic                     pci_clock_halt_n_in,
    input  wire logic                     link_clock_halt_n_in,
    output logic                          pci_clock_output_out,
    output logic                          link_clock_output_out,
    output logic [7:0]                    wr_data_out,
    output logic                          wr_valid_out,
    input  wire logic                     wr_ready_in,
    input  wire logic [RD_COUNT-1:0][7:0] rd_bytes_in
);
    localparam int NCH = scp_pkg::NUM_CH;
    localparam logic [7:0] RD_CNT_B = 8'(RD_COUNT);
    localparam int SDA_DLY  = int'(scp_pkg::SDA_DELAY_CYC);
    localparam int SDA_PAST = SDA_DLY + 1;

    typedef struct packed {
        logic                    scl_m;
        logic                    scl_s;
        logic                    scl_p;
        logic                    sda_m;
        logic                    sda_s;
        logic                    sda_p;
        logic [NCH-1:0]          src_m;
        logic [NCH-1:0]          src_s;
        logic [NCH-1:0]          halt_m;
        logic [NCH-1:0]          halt_s;
        logic [NCH-1:0]          gate_en;
        logic [NCH-1:0]          gate_out;
        scp_pkg::scp_state_t     state;
        logic [3:0]              bit_cnt;
        logic [7:0]              byte_idx;
        logic [7:0]              shift;
        logic [7:0]              tx_shift;
        logic [7:0]              tx_idx;
        logic                    rw;
        logic                    ack_seen;
        logic                    pend_val;
        logic [scp_pkg::DLY_W-1:0] dly_cnt;
        logic                    sda_drive;
    } scp_state_s_t;

    scp_state_s_t s;
    scp_state_s_t next_s;
    logic         scl_rise;
    logic         scl_fall;
    logic         start_cond;
    logic         stop_cond;
    logic         push;
    logic         fifo_ready;
    logic         ack_ok;
    logic [7:0]   rd_byte;

    // ****************************************
    // bus conditions
    // ****************************************
    assign scl_rise   = s.scl_s && !s.scl_p;
    assign scl_fall   = !s.scl_s && s.scl_p;
    assign start_cond = s.scl_s && s.scl_p && s.sda_p && !s.sda_s;
    assign stop_cond  = s.scl_s && s.scl_p && !s.sda_p && s.sda_s;

    always_comb begin
        rd_byte = scp_pkg::PAD_BYTE;
        if (32'(s.tx_idx) < RD_COUNT) begin
            rd_byte = rd_bytes_in[s.tx_idx];
        end
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_s = s;
        push = 1'b0;
        ack_ok = 1'b0;
        next_s.scl_m = serial_clock_line_in;
        next_s.scl_s = s.scl_m;
        next_s.scl_p = s.scl_s;
        next_s.sda_m = serial_data_line_in;
        next_s.sda_s = s.sda_m;
        next_s.sda_p = s.sda_s;
        next_s.src_m = {link_clock_src_in, pci_clock_src_in};
        next_s.src_s = s.src_m;
        next_s.halt_m = {link_clock_halt_n_in, pci_clock_halt_n_in};
        next_s.halt_s = s.halt_m;
        for (int ch = 0; ch < NCH; ch++) begin
            if (!s.src_s[ch]) begin
                next_s.gate_en[ch] = s.halt_s[ch];
            end
            next_s.gate_out[ch] = s.src_s[ch] && s.gate_en[ch];
        end
        if (s.dly_cnt != scp_pkg::DLY_IDLE) begin
            next_s.dly_cnt = scp_pkg::DLY_W'(s.dly_cnt - 1'b1);
            if (s.dly_cnt == scp_pkg::DLY_LAST) begin
                next_s.sda_drive = s.pend_val;
            end
        end
        if (scl_fall) begin
            next_s.dly_cnt = scp_pkg::SDA_DELAY_CYC;
        end
        if (start_cond) begin
            next_s.state = scp_pkg::ST_RX;
            next_s.bit_cnt = '0;
            next_s.byte_idx = scp_pkg::IDX_ADDR;
        end else if (stop_cond) begin
            next_s.state = scp_pkg::ST_IDLE;
        end else begin
            unique case (s.state)
                scp_pkg::ST_IDLE: begin
                    next_s.pend_val = 1'b0;
                end
                scp_pkg::ST_RX: begin
                    if (scl_rise) begin
                        next_s.shift = {s.shift[6:0], s.sda_s};
                        next_s.bit_cnt = 4'(s.bit_cnt + 1'b1);
                    end
                    if (scl_fall && s.bit_cnt == scp_pkg::BITS_BYTE) begin
                        next_s.bit_cnt = '0;
                        if (s.byte_idx == scp_pkg::IDX_ADDR) begin
                            ack_ok = (s.shift[7:1] == DEV_ADDR);
                            next_s.rw = s.shift[0];
                        end else if (s.byte_idx >= scp_pkg::IDX_DATA0) begin
                            ack_ok = fifo_ready;
                            push = fifo_ready;
                        end else begin
                            ack_ok = 1'b1;
                        end
                        next_s.pend_val = ack_ok;
                        next_s.state = ack_ok ? scp_pkg::ST_ACK : scp_pkg::ST_IDLE;
                    end
                end
                scp_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        if (s.byte_idx != scp_pkg::IDX_MAX) begin
                            next_s.byte_idx = 8'(s.byte_idx + 1'b1);
                        end
                        if (s.rw && s.byte_idx == scp_pkg::IDX_ADDR) begin
                            next_s.state = scp_pkg::ST_TX;
                            next_s.tx_shift = RD_CNT_B;
                            next_s.tx_idx = '0;
                            next_s.bit_cnt = scp_pkg::BIT_FIRST;
                            next_s.pend_val = !RD_CNT_B[7];
                        end else begin
                            next_s.state = scp_pkg::ST_RX;
                            next_s.pend_val = 1'b0;
                        end
                    end
                end
                scp_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (s.bit_cnt == scp_pkg::BITS_BYTE) begin
                            next_s.state = scp_pkg::ST_RACK;
                            next_s.pend_val = 1'b0;
                        end else begin
                            next_s.tx_shift = {s.tx_shift[6:0], 1'b0};
                            next_s.pend_val = !s.tx_shift[6];
                            next_s.bit_cnt = 4'(s.bit_cnt + 1'b1);
                        end
                    end
                end
                scp_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        next_s.ack_seen = !s.sda_s;
                    end
                    if (scl_fall) begin
                        if (s.ack_seen) begin
                            next_s.state = scp_pkg::ST_TX;
                            next_s.tx_shift = rd_byte;
                            next_s.tx_idx = 8'(s.tx_idx + 1'b1);
                            next_s.bit_cnt = scp_pkg::BIT_FIRST;
                            next_s.pend_val = !rd_byte[7];
                        end else begin
                            next_s.state = scp_pkg::ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            s <= '0;
            s.state <= scp_pkg::ST_IDLE;
            s.gate_en <= '1;
            s.scl_m <= 1'b1;
            s.scl_s <= 1'b1;
            s.scl_p <= 1'b1;
            s.sda_m <= 1'b1;
            s.sda_s <= 1'b1;
            s.sda_p <= 1'b1;
            s.halt_m <= '1;
            s.halt_s <= '1;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************
    // write data buffer
    // ****************************************
    scp_fifo #(
        .W (8),
        .D (FIFO_D)
    ) u_fifo (
        .clock_in      (clock_in),
        .rst_n_in      (rst_n_in),
        .in_data_in    (s.shift),
        .in_valid_in   (push),
        .in_ready_out  (fifo_ready),
        .out_data_out  (wr_data_out),
        .out_valid_out (wr_valid_out),
        .out_ready_in  (wr_ready_in)
    );

    // ****************************************
    // outputs
    // ****************************************
    assign serial_data_line_out      = 1'b0;
    assign serial_data_line_en_n_out = !s.sda_drive;
    assign pci_clock_output_out      = s.gate_out[scp_pkg::CH_PCI];
    assign link_clock_output_out     = s.gate_out[scp_pkg::CH_LINK];

    // ****************************************
    // checks
    // ****************************************
    sequence addr_match_s;
        s.state == scp_pkg::ST_RX && scl_fall && s.bit_cnt == scp_pkg::BITS_BYTE
            && s.byte_idx == scp_pkg::IDX_ADDR && s.shift[7:1] == DEV_ADDR;
    endsequence
    sequence ack_drive_s;
        s.state == scp_pkg::ST_ACK && s.pend_val ##SDA_DLY s.sda_drive;
    endsequence
    sequence link_resume_s;
        s.halt_s[scp_pkg::CH_LINK] && !s.src_s[scp_pkg::CH_LINK]
            ##1 s.src_s[scp_pkg::CH_LINK];
    endsequence

    sda_delay_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        $changed(s.sda_drive) |-> $past(scl_fall, SDA_PAST))
        else $error("data line changed off the delayed slot");
    restart_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        start_cond && s.state != scp_pkg::ST_IDLE |=>
            s.state == scp_pkg::ST_RX && s.byte_idx == scp_pkg::IDX_ADDR && s.bit_cnt == '0)
        else $error("repeated start not taken");
    full_nack_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        s.state == scp_pkg::ST_RX && scl_fall && s.bit_cnt == scp_pkg::BITS_BYTE
            && s.byte_idx >= scp_pkg::IDX_DATA0 && !fifo_ready && !start_cond
            |=> s.state == scp_pkg::ST_IDLE && !s.pend_val)
        else $error("full buffer did not refuse byte");
    push_order_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        push |-> s.byte_idx >= scp_pkg::IDX_DATA0 && !s.rw)
        else $error("byte stored outside data phase");
    addr_ack_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        addr_match_s |=> ack_drive_s)
        else $error("address not acknowledged on time");
    pci_edge_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        $changed(s.gate_en[scp_pkg::CH_PCI]) |-> !$past(s.src_s[scp_pkg::CH_PCI]))
        else $error("pci gate moved inside a pulse");
    link_edge_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        $changed(s.gate_en[scp_pkg::CH_LINK]) |-> !$past(s.src_s[scp_pkg::CH_LINK]))
        else $error("link gate moved inside a pulse");
    halt_stop_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        !s.halt_s[scp_pkg::CH_LINK] && !s.src_s[scp_pkg::CH_LINK]
            |=> ##1 !link_clock_output_out)
        else $error("pulse sent after halt");
    pci_halt_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        !s.halt_s[scp_pkg::CH_PCI] && !s.src_s[scp_pkg::CH_PCI]
            |=> ##1 !pci_clock_output_out)
        else $error("pci pulse sent after halt");
    link_resume_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        link_resume_s |=> link_clock_output_out)
        else $error("no link pulse after release");
    pci_gate_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        pci_clock_output_out |-> s.gate_en[scp_pkg::CH_PCI])
        else $error("pci pulse while gated");
    link_gate_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        link_clock_output_out |-> s.gate_en[scp_pkg::CH_LINK])
        else $error("link pulse while gated");
    read_nack_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        s.state == scp_pkg::ST_RACK && scl_fall && !s.ack_seen
            |=> s.state == scp_pkg::ST_IDLE)
        else $error("host refusal did not end read");
    stop_idle_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        stop_cond |=> s.state == scp_pkg::ST_IDLE)
        else $error("stop did not end transfer");
    push_show_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        push |=> wr_valid_out)
        else $error("stored byte not offered");
endmodule

// File: test/scp_host_model.sv
// scp_host_model: serial bus host issuing starts, stops and bytes
// assumes the bench resolves the open drain data line with a pull-up
`timescale 1ns/1ns
module scp_host_model #(
    parameter int LO = 140,
    parameter int HI = 60
) (
    input  wire logic clock_in,
    input  wire logic sda_line_in,
    output logic      scl_out,
    output logic      sda_out
);
    int dly;

    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
        dly = 0;
    end

    // ****************************************
    // bit and byte cycles
    // ****************************************
    // clock is driven blind, never waits on a stretched low
    task automatic bit_io(input logic b, output logic s);
        dly = 0;
        for (int i = 0; i < LO; i++) begin
            @(posedge clock_in);
            if (i == 3) begin
                sda_out <= b;
            end
            if (dly == 0 && i > 4 && b && sda_line_in === 1'b0) begin
                dly = i + 1;
            end
        end
        scl_out <= 1'b1;
        repeat (HI / 2) @(posedge clock_in);
        s = sda_line_in;
        repeat (HI / 2) @(posedge clock_in);
        scl_out <= 1'b0;
    endtask

    // also serves as repeated start mid-transfer
    task automatic start();
        @(posedge clock_in);
        sda_out <= 1'b1;
        repeat (LO) @(posedge clock_in);
        scl_out <= 1'b1;
        repeat (HI) @(posedge clock_in);
        sda_out <= 1'b0;
        repeat (HI) @(posedge clock_in);
        scl_out <= 1'b0;
    endtask

    task automatic stop();
        @(posedge clock_in);
        sda_out <= 1'b0;
        repeat (LO) @(posedge clock_in);
        scl_out <= 1'b1;
        repeat (HI) @(posedge clock_in);
        sda_out <= 1'b1;
        repeat (HI) @(posedge clock_in);
    endtask

    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
        end
        bit_io(1'b1, s);
        ack = (s === 1'b0);
    endtask

    task automatic rd_byte(output logic [7:0] b, input logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            b[i] = s;
        end
        bit_io(nack, s);
    endtask
endmodule

// File: test/smbus_control_port_test.sv
// smbus_control_port_test: self-checking bench for the serial control port
// assumes scp_pkg, scp_fifo, scp_control_port and scp_host_model compiled first
`timescale 1ns/1ns
module smbus_control_port_test;
    localparam int         RD_COUNT = 7;
    localparam logic [6:0] ADDR     = scp_pkg::DEF_DEV_ADDR;

    logic                     clock_in    = 1'b0;
    logic                     rst_n_in    = 1'b0;
    logic                     pci_src     = 1'b0;
    logic                     link_src    = 1'b0;
    logic                     pci_halt_n  = 1'b1;
    logic                     link_halt_n = 1'b1;
    logic                     wr_ready    = 1'b0;
    logic                     scl;
    logic                     host_sda;
    logic                     sda_line;
    logic                     dut_sda;
    logic                     dut_en_n;
    logic                     pci_out;
    logic                     link_out;
    logic                     wr_valid;
    logic [7:0]               wr_data;
    logic [RD_COUNT-1:0][7:0] rd_bytes;
    int                       n_errors = 0;
    int                       n_tests  = 0;
    int                       cyc      = 0;
    int                       pci_len  = 0;
    int                       link_len = 0;

    always #2 clock_in = ~clock_in;
    assign sda_line = host_sda & (dut_en_n | dut_sda);

    scp_control_port u_dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .serial_clock_line_in(scl), .serial_data_line_in(sda_line),
        .serial_data_line_out(dut_sda), .serial_data_line_en_n_out(dut_en_n),
        .pci_clock_src_in(pci_src), .link_clock_src_in(link_src),
        .pci_clock_halt_n_in(pci_halt_n), .link_clock_halt_n_in(link_halt_n),
        .pci_clock_output_out(pci_out), .link_clock_output_out(link_out),
        .wr_data_out(wr_data), .wr_valid_out(wr_valid), .wr_ready_in(wr_ready),
        .rd_bytes_in(rd_bytes));

    scp_host_model u_host (.clock_in(clock_in), .sda_line_in(sda_line),
        .scl_out(scl), .sda_out(host_sda));

    // ****************************************
    // checking and closing
    // ****************************************
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ****************************************
    // sources, pulse monitor, timeout
    // ****************************************
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        pci_src <= cyc[2];
        link_src <= cyc[1];
        pci_len <= (pci_out === 1'b1) ? pci_len + 1 : 0;
        link_len <= (link_out === 1'b1) ? link_len + 1 : 0;
        if (cyc > 30 && pci_out === 1'b0 && pci_len != 0) begin
            check(8'(pci_len), 8'h04);
        end
        if (cyc > 30 && link_out === 1'b0 && link_len != 0) begin
            check(8'(link_len), 8'h02);
        end
        if (cyc == 60000) begin
            n_errors++;
            end_sim();
        end
    end

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_write_fill();
        logic       a;
        logic [7:0] d [5];
        d = '{8'ha5, 8'h3c, 8'h00, 8'hff, 8'h96};
        u_host.start();
        u_host.wr_byte({ADDR, 1'b0}, a);
        check(8'(a), 8'h01);
        check(8'(u_host.dly >= 111 && u_host.dly <= 117), 8'h01);
        u_host.wr_byte(8'h5a, a);
        check(8'(a), 8'h01);
        u_host.wr_byte(8'h05, a);
        check(8'(a), 8'h01);
        for (int k = 0; k < 5; k++) begin
            u_host.wr_byte(d[k], a);
            check(8'(a), 8'(k < 4));
        end
        u_host.stop();
        for (int k = 0; k < 4; k++) begin
            @(posedge clock_in);
            #1;
            check(8'(wr_valid), 8'h01);
            check(wr_data, d[k]);
            @(posedge clock_in);
            wr_ready <= 1'b1;
            @(posedge clock_in);
            wr_ready <= 1'b0;
        end
        @(posedge clock_in);
        #1;
        check(8'(wr_valid), 8'h00);
        $display("test write_fill done");
    endtask

    task automatic t_bad_addr();
        logic a;
        u_host.start();
        u_host.wr_byte({ADDR ^ 7'h01, 1'b0}, a);
        check(8'(a), 8'h00);
        u_host.stop();
        $display("test bad_addr done");
    endtask

    task automatic t_rstart_read();
        logic       a;
        logic [7:0] b;
        u_host.start();
        u_host.wr_byte({ADDR, 1'b0}, a);
        u_host.wr_byte(8'h00, a);
        u_host.start();
        u_host.wr_byte({ADDR, 1'b1}, a);
        check(8'(a), 8'h01);
        u_host.rd_byte(b, 1'b0);
        check(b, 8'(RD_COUNT));
        u_host.rd_byte(b, 1'b0);
        check(b, rd_bytes[0]);
        u_host.rd_byte(b, 1'b1);
        check(b, rd_bytes[1]);
        u_host.stop();
        $display("test rstart_read done");
    endtask

    task automatic watch(input int n, output logic [1:0] seen);
        seen = 2'b00;
        repeat (n) begin
            @(posedge clock_in);
            #1;
            seen = seen | {link_out, pci_out};
        end
    endtask

    task automatic t_halt();
        logic [1:0] seen;
        @(posedge clock_in);
        pci_halt_n <= 1'b0;
        link_halt_n <= 1'b0;
        repeat (20) @(posedge clock_in);
        watch(40, seen);
        check({6'h00, seen}, 8'h00);
        @(posedge clock_in);
        pci_halt_n <= 1'b1;
        link_halt_n <= 1'b1;
        watch(20, seen);
        check({6'h00, seen}, 8'h03);
        $display("test halt done");
    endtask

    initial begin
        for (int k = 0; k < RD_COUNT; k++) begin
            rd_bytes[k] = 8'h40 + 8'(k);
        end
        repeat (2) @(posedge clock_in);
        rst_n_in <= 1'b1;
        repeat (10) @(posedge clock_in);
        t_write_fill();
        t_bad_addr();
        t_rstart_read();
        t_halt();
        end_sim();
    end
endmodule
